// *** hw/capture_consts.vh ***
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_FIRST_BASE 8'h04
`define OFS_SECOND_BASE 8'h08
`define OFS_LENGTH 8'h0C
// Write-only pattern that resets the unit
`define SOFT_RESET_WORD 32'h80000000
// Control register fields
`define BIT_CAPTURE_ON 0
`define BIT_FIRST_IRQ_ON 1
`define BIT_SECOND_IRQ_ON 2
`define BIT_OVERRUN_IRQ_ON 3
`define BIT_HBE_IRQ_ON 4
`define BIT_KEEP_AWAKE 5
`define BIT_ACK_FIRST 6
`define BIT_ACK_SECOND 7
`define BIT_ACK_OVERRUN 8
`define BIT_ACK_HBE 9
`define BIT_FIRST_FILLED 10
`define BIT_SECOND_FILLED 11
`define BIT_OVERRUN 12
`define BIT_HBE 13
`define BIT_FIRST_SELECTED 14
`define BIT_MODE_STEREO 16
`define BIT_MODE_WIDE 17
`define CTRL_RESET 6'h00
// Base and length fields keep bits 31:6
`define ALIGN_LSB 6
`define ALIGN_ZERO 6'h00
// Staging memory: 16 words of 32 bits is 64 bytes
`define STAGE_WORDS 16
`define STAGE_AW 4
`define STAGE_LAST 4'hF
`endif

// *** hw/stage_mem.v ***
`timescale 1ns/1ps
`default_nettype none
// 64-byte staging store, registered read
module stage_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // stage_mem
`default_nettype wire

// *** hw/audio_capture_dma.v ***
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "capture_consts.vh"
module audio_capture_dma (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Parallel samples from the serial converter
  input wire sample_valid,
  input wire [15:0] sample_left,
  input wire [15:0] sample_right,
  // Memory highway write port
  output reg mem_req,
  output reg [31:0] mem_addr,
  input wire mem_grant,
  output reg mem_wvalid,
  output wire [31:0] mem_wdata,
  // Power and interrupt
  input wire global_power_down,
  input wire unit_power_off,
  output wire irq,
  output wire wake_request
);
  localparam ST_IDLE = 3'b001;
  localparam ST_REQ = 3'b010;
  localparam ST_BURST = 3'b100;

  // Bytes one sample takes in memory
  function [2:0] sample_bytes;
    input stereo;
    input wide;
    begin
      case ({wide, stereo})
        2'b00: sample_bytes = 3'h1;
        2'b01: sample_bytes = 3'h2;
        2'b10: sample_bytes = 3'h2;
        default: sample_bytes = 3'h4;
      endcase
    end
  endfunction

  // Control and status
  reg capture_on, first_buffer_irq_on, second_buffer_irq_on;
  reg overrun_irq_on, hbe_irq_on, keep_awake, mode_stereo, mode_wide;
  reg first_buffer_filled, second_buffer_filled, overrun, highway_bandwidth_error;
  reg first_buffer_selected;
  reg [31:`ALIGN_LSB] first_buffer_base, second_buffer_base, buffer_length;
  // Bus data phase
  reg wr_pend;
  reg [7:0] wr_addr;
  // Holding register
  reg hold_full;
  reg [15:0] hold_left, hold_right;
  // Packing and staging
  reg [31:0] word_acc;
  reg [1:0] byte_pos;
  reg [`STAGE_AW-1:0] word_idx;
  reg [31:0] sample_count, buf_offset;
  reg block_pending, block_last, block_first;
  reg [2:0] state;
  reg [`STAGE_AW-1:0] rd_idx;
  reg rd_active;
  reg [`STAGE_AW:0] sent;

  wire addr_phase = hsel & hready & htrans[1];
  wire wr_ctrl = wr_pend & (wr_addr == `OFS_CONTROL);
  wire soft_reset = wr_ctrl & (hwdata == `SOFT_RESET_WORD);
  wire ctrl_wr = wr_ctrl & ~soft_reset;
  wire ack_first = ctrl_wr & hwdata[`BIT_ACK_FIRST];
  wire ack_second = ctrl_wr & hwdata[`BIT_ACK_SECOND];
  wire ack_overrun = ctrl_wr & hwdata[`BIT_ACK_OVERRUN];
  wire ack_hbe = ctrl_wr & hwdata[`BIT_ACK_HBE];

  // Unit runs unless powered off, or globally down without keep-awake
  wire powered = ~unit_power_off & ~(global_power_down & ~keep_awake);
  wire running = powered & capture_on & (buffer_length != 26'h0);
  wire drain = running & hold_full & ~block_pending;
  wire active_filled = first_buffer_selected ? first_buffer_filled : second_buffer_filled;
  wire accept = drain & ~active_filled;
  wire lost = drain & active_filled;
  wire bw_error = running & sample_valid & hold_full & block_pending;

  // Packing of one sample into the word accumulator
  wire [2:0] nbytes = sample_bytes(mode_stereo, mode_wide);
  reg [31:0] sample_data;
  always @* begin
    case ({mode_wide, mode_stereo})
      2'b00: sample_data = {24'h000000, hold_left[15:8]};
      2'b01: sample_data = {16'h0000, hold_right[15:8], hold_left[15:8]};
      2'b10: sample_data = {16'h0000, hold_left};
      default: sample_data = {hold_right, hold_left};
    endcase
  end
  wire [31:0] next_acc = (byte_pos == 2'h0 ? 32'h0 : word_acc) |
    (sample_data << {byte_pos, 3'h0});
  wire [2:0] pos_sum = {1'b0, byte_pos} + nbytes;
  wire word_done = accept & (pos_sum[2] | (nbytes == 3'h4));
  wire block_done = word_done & (word_idx == `STAGE_LAST);
  wire [31:0] next_count = sample_count + 32'h1;
  wire buf_end = accept & (next_count == {buffer_length, `ALIGN_ZERO});
  wire [31:0] active_base = first_buffer_selected ?
    {first_buffer_base, `ALIGN_ZERO} : {second_buffer_base, `ALIGN_ZERO};
  wire burst_end = mem_wvalid & (sent == {1'b0, `STAGE_LAST});

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = (first_buffer_filled & first_buffer_irq_on) |
    (second_buffer_filled & second_buffer_irq_on) |
    (overrun & overrun_irq_on) |
    (highway_bandwidth_error & hbe_irq_on);
  assign wake_request = irq & global_power_down & keep_awake;

  // Bus address phase and registered read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr;
      if (addr_phase & ~hwrite) begin
        case (haddr)
          `OFS_CONTROL: hrdata <= {14'h0000, mode_wide, mode_stereo, 1'b0,
            first_buffer_selected, highway_bandwidth_error, overrun, second_buffer_filled,
            first_buffer_filled, 4'h0, keep_awake, hbe_irq_on, overrun_irq_on,
            second_buffer_irq_on, first_buffer_irq_on, capture_on};
          `OFS_FIRST_BASE: hrdata <= {first_buffer_base, `ALIGN_ZERO};
          `OFS_SECOND_BASE: hrdata <= {second_buffer_base, `ALIGN_ZERO};
          `OFS_LENGTH: hrdata <= {buffer_length, `ALIGN_ZERO};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Control fields, buffer fields and sticky flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {capture_on, first_buffer_irq_on, second_buffer_irq_on, overrun_irq_on} <= 4'h0;
      {hbe_irq_on, keep_awake, mode_stereo, mode_wide} <= 4'h0;
      {first_buffer_filled, second_buffer_filled, overrun, highway_bandwidth_error} <= 4'h0;
      {first_buffer_base, second_buffer_base, buffer_length} <= 78'h0;
    end else if (soft_reset) begin
      {capture_on, first_buffer_irq_on, second_buffer_irq_on, overrun_irq_on} <= 4'h0;
      {hbe_irq_on, keep_awake, mode_stereo, mode_wide} <= 4'h0;
      {first_buffer_filled, second_buffer_filled, overrun, highway_bandwidth_error} <= 4'h0;
      {first_buffer_base, second_buffer_base, buffer_length} <= 78'h0;
    end else begin
      if (ctrl_wr) begin
        capture_on <= hwdata[`BIT_CAPTURE_ON];
        first_buffer_irq_on <= hwdata[`BIT_FIRST_IRQ_ON];
        second_buffer_irq_on <= hwdata[`BIT_SECOND_IRQ_ON];
        overrun_irq_on <= hwdata[`BIT_OVERRUN_IRQ_ON];
        hbe_irq_on <= hwdata[`BIT_HBE_IRQ_ON];
        keep_awake <= hwdata[`BIT_KEEP_AWAKE];
        mode_stereo <= hwdata[`BIT_MODE_STEREO];
        mode_wide <= hwdata[`BIT_MODE_WIDE];
      end
      if (wr_pend & (wr_addr == `OFS_FIRST_BASE)) begin
        first_buffer_base <= hwdata[31:`ALIGN_LSB];
      end
      if (wr_pend & (wr_addr == `OFS_SECOND_BASE)) begin
        second_buffer_base <= hwdata[31:`ALIGN_LSB];
      end
      if (wr_pend & (wr_addr == `OFS_LENGTH)) begin
        buffer_length <= hwdata[31:`ALIGN_LSB];
      end
      // Set wins over acknowledge in the same cycle
      if (burst_end & block_last & block_first) begin
        first_buffer_filled <= 1'b1;
      end else if (ack_first) begin
        first_buffer_filled <= 1'b0;
      end
      if (burst_end & block_last & ~block_first) begin
        second_buffer_filled <= 1'b1;
      end else if (ack_second) begin
        second_buffer_filled <= 1'b0;
      end
      if (lost) begin
        overrun <= 1'b1;
      end else if (ack_overrun) begin
        overrun <= 1'b0;
      end
      if (bw_error) begin
        highway_bandwidth_error <= 1'b1;
      end else if (ack_hbe) begin
        highway_bandwidth_error <= 1'b0;
      end
    end
  end

  // Holding register, packing, buffer alternation
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {hold_full, block_pending, block_last, byte_pos} <= 5'h00;
      {hold_left, hold_right, word_acc} <= 64'h0;
      {sample_count, buf_offset, mem_addr} <= 96'h0;
      word_idx <= {`STAGE_AW{1'b0}};
      {first_buffer_selected, block_first} <= 2'h3;
    end else if (soft_reset) begin
      {hold_full, block_pending, block_last, byte_pos} <= 5'h00;
      {sample_count, buf_offset} <= 64'h0;
      word_idx <= {`STAGE_AW{1'b0}};
      {first_buffer_selected, block_first} <= 2'h3;
    end else begin
      // Holder takes a new sample while its old one drains
      if (running & sample_valid & (~hold_full | drain)) begin
        hold_full <= 1'b1;
        hold_left <= sample_left;
        hold_right <= sample_right;
      end else if (drain) begin
        hold_full <= 1'b0;
      end
      if (accept) begin
        word_acc <= next_acc;
        byte_pos <= pos_sum[1:0];
        if (word_idx == {`STAGE_AW{1'b0}} && byte_pos == 2'h0) begin
          mem_addr <= active_base + buf_offset;
        end
        if (word_done) begin
          word_idx <= word_idx + {{(`STAGE_AW-1){1'b0}}, 1'b1};
        end
        if (buf_end) begin
          sample_count <= 32'h00000000;
          buf_offset <= 32'h00000000;
          first_buffer_selected <= ~first_buffer_selected;
        end else begin
          sample_count <= next_count;
          buf_offset <= buf_offset + {29'h0, nbytes};
        end
        if (block_done) begin
          block_pending <= 1'b1;
          block_last <= buf_end;
          block_first <= first_buffer_selected;
        end
      end else if (burst_end) begin
        block_pending <= 1'b0;
      end
    end
  end

  // Block write to memory; soft reset abandons a request or burst
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      {mem_req, rd_active, mem_wvalid} <= 3'h0;
      rd_idx <= {`STAGE_AW{1'b0}};
      sent <= {(`STAGE_AW+1){1'b0}};
    end else if (soft_reset) begin
      state <= ST_IDLE;
      {mem_req, rd_active, mem_wvalid} <= 3'h0;
    end else begin
      mem_wvalid <= rd_active;
      case (state)
        ST_IDLE: begin
          sent <= {(`STAGE_AW+1){1'b0}};
          if (block_pending & powered & ~soft_reset) begin
            state <= ST_REQ;
            mem_req <= 1'b1;
          end
        end
        ST_REQ: begin
          if (mem_grant) begin
            state <= ST_BURST;
            mem_req <= 1'b0;
            rd_idx <= {`STAGE_AW{1'b0}};
            rd_active <= 1'b1;
          end
        end
        ST_BURST: begin
          if (rd_idx == `STAGE_LAST) begin
            rd_active <= 1'b0;
          end
          rd_idx <= rd_idx + {{(`STAGE_AW-1){1'b0}}, 1'b1};
          if (mem_wvalid) begin
            sent <= sent + {{`STAGE_AW{1'b0}}, 1'b1};
          end
          if (burst_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          {mem_req, rd_active} <= 2'h0;
        end
      endcase
    end
  end

  stage_mem #(
    .WIDTH(32),
    .DEPTH(`STAGE_WORDS),
    .AW(`STAGE_AW)
  ) u_stage (
    .clk(hclk),
    .wr_en(word_done),
    .wr_addr(word_idx),
    .wr_data(next_acc),
    .rd_en(rd_active),
    .rd_addr(rd_idx),
    .rd_data(mem_wdata)
  );
endmodule // audio_capture_dma
`default_nettype wire

// *** dv/capture_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "capture_consts.vh"
module capture_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Samples and memory
  input wire logic sample_valid,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_grant,
  input wire logic mem_wvalid,
  // Power and interrupt
  input wire logic global_power_down,
  input wire logic unit_power_off,
  input wire logic irq,
  input wire logic wake_request
);
  logic wr_ctl;
  logic rd_reg;
  wire take = hsel && hready && htrans[1];
  wire soft_now = wr_ctl && hwdata == `SOFT_RESET_WORD;
  // Data phase of a control write, or of a base or length read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_ctl <= take && hwrite && haddr == `OFS_CONTROL;
      rd_reg <= take && !hwrite && haddr[7:4] == 4'h0 && haddr[3:2] != 2'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence grant_s;
    mem_req && mem_grant;
  endsequence
  sequence burst_s;
    !mem_req && !mem_wvalid ##1 mem_wvalid [*8] ##1 mem_wvalid [*8] ##1 !mem_wvalid;
  endsequence
  burst_len_a: assert property (disable iff (!hresetn || soft_now) grant_s |=> burst_s)
    else $error("block burst not sixteen words after grant");
  burst_cause_a: assert property ($rose(mem_wvalid) |-> $past(mem_grant, 2))
    else $error("burst without grant");
  req_hold_a: assert property (mem_req && !mem_grant && !soft_now |=> mem_req && $stable(mem_addr))
    else $error("request dropped or address moved");
  block_align_a: assert property (mem_req |-> mem_addr[5:0] == `ALIGN_ZERO)
    else $error("block address not aligned");
  low_bits_a: assert property (rd_reg |-> hrdata[5:0] == `ALIGN_ZERO)
    else $error("base or length low bits not zero");
  ack_drop_a: assert property (wr_ctl && !mem_wvalid && !sample_valid
    && (hwdata[4:1] & ~hwdata[9:6]) == 4'h0 |=> !irq)
    else $error("request stayed after acknowledge");
  soft_rst_a: assert property (soft_now |=> !irq && !mem_req && !mem_wvalid ##1 !irq)
    else $error("soft reset left activity");
  wake_cause_a: assert property (wake_request |-> irq && global_power_down)
    else $error("wake without request in power down");
  poff_quiet_a: assert property (unit_power_off && $past(unit_power_off) |-> !$rose(mem_req))
    else $error("memory request while powered off");
endmodule // capture_chk
bind audio_capture_dma capture_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .sample_valid, .mem_req, .mem_addr, .mem_grant, .mem_wvalid,
  .global_power_down, .unit_power_off, .irq, .wake_request);
`default_nettype wire

// *** dv/mem_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Highway write port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_grant,
  input wire logic mem_wvalid,
  input wire logic [31:0] mem_wdata
);
  int lat = 3;
  int wait_cnt = 0;
  int words = 0;
  int blocks = 0;
  logic [31:0] first_addr;
  logic [31:0] word0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_grant <= 1'b0;
      wait_cnt <= 0;
    end else begin
      mem_grant <= 1'b0;
      if (mem_req && !mem_grant) begin
        if (wait_cnt >= lat) begin
          mem_grant <= 1'b1;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
  // Keeps first address and word of each block
  always @(posedge hclk) begin
    if (mem_wvalid) begin
      if (words % 16 == 0) begin
        first_addr <= mem_addr;
        word0 <= mem_wdata;
      end
      if (words % 16 == 15) blocks <= blocks + 1;
      words <= words + 1;
    end
  end
endmodule // mem_partner
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "capture_consts.vh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sample_valid = 1'b0;
  logic [15:0] sample_left = 16'h0;
  logic [15:0] sample_right = 16'h0;
  logic global_power_down = 1'b0;
  logic unit_power_off = 1'b0;
  wire hready, hreadyout, hresp, mem_req, mem_grant, mem_wvalid, irq, wake_request;
  wire [31:0] hrdata, mem_addr, mem_wdata;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] rd;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  audio_capture_dma dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .sample_valid, .sample_left, .sample_right,
    .mem_req, .mem_addr, .mem_grant, .mem_wvalid, .mem_wdata, .global_power_down,
    .unit_power_off, .irq, .wake_request);
  mem_partner p (.hclk, .hresetn, .mem_req, .mem_addr, .mem_grant, .mem_wvalid, .mem_wdata);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) hang();
  endtask
  // Single word transfer; read data kept in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic send(input int n, input int k0);
    for (int k = k0; k < k0 + n; k++) begin
      @(posedge hclk);
      sample_valid <= 1'b1;
      sample_left <= {k[7:0], 8'h5A};
      sample_right <= {8'hC3, k[7:0]};
      @(posedge hclk);
      sample_valid <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask
  task automatic wait_blocks(input int b);
    int n;
    n = 0;
    while (p.blocks < b && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (p.blocks < b) hang();
    repeat (2) @(posedge hclk);
  endtask
  task automatic setup(input logic [31:0] ctl);
    bus(1'b1, `OFS_FIRST_BASE, 32'h0000_1000);
    bus(1'b1, `OFS_SECOND_BASE, 32'h0000_2000);
    bus(1'b1, `OFS_LENGTH, 32'h0000_0040);
    repeat (5) @(posedge hclk);
    bus(1'b1, `OFS_CONTROL, ctl);
  endtask
  // One block in a given capture mode, first word checked
  task automatic mode_run(input logic [31:0] ctl, input int n, input int b,
    input logic [31:0] w0);
    bus(1'b1, `OFS_CONTROL, `SOFT_RESET_WORD);
    setup(ctl);
    send(n, 0);
    wait_blocks(b);
    check(p.word0, w0);
  endtask
  task automatic test_end(input string name);
    $display("done: %s", name);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`OFS_CONTROL, 32'h0000_4000);
    bus(1'b1, `OFS_FIRST_BASE, 32'h1234_567F);
    rchk(`OFS_FIRST_BASE, 32'h1234_5640);
    bus(1'b1, `OFS_LENGTH, 32'h0000_007F);
    rchk(`OFS_LENGTH, 32'h0000_0040);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0);
    check(hresp, 1'b0);
    test_end("reset and alignment");
    bus(1'b1, `OFS_CONTROL, `SOFT_RESET_WORD);
    setup(32'h0000_0007);
    send(64, 0);
    wait_blocks(1);
    check(p.first_addr, 32'h0000_1000);
    check(p.word0, 32'h0302_0100);
    check(irq, 1'b1);
    rchk(`OFS_CONTROL, 32'h0000_0407);
    check(irq, 1'b1);
    bus(1'b1, `OFS_CONTROL, 32'h0000_00C7);
    #1 check(irq, 1'b0);
    rchk(`OFS_CONTROL, 32'h0000_0007);
    send(64, 64);
    wait_blocks(2);
    check(p.first_addr, 32'h0000_2000);
    rchk(`OFS_CONTROL, 32'h0000_4807);
    send(64, 128);
    wait_blocks(3);
    check(p.first_addr, 32'h0000_1000);
    send(1, 192);
    rchk(`OFS_CONTROL, 32'h0000_1C07);
    bus(1'b1, `OFS_CONTROL, 32'h0000_00C7);
    rchk(`OFS_CONTROL, 32'h0000_1007);
    bus(1'b1, `OFS_CONTROL, 32'h0000_0107);
    rchk(`OFS_CONTROL, 32'h0000_0007);
    test_end("double buffer");
    bus(1'b1, `OFS_CONTROL, `SOFT_RESET_WORD);
    rchk(`OFS_CONTROL, 32'h0000_4000);
    rchk(`OFS_SECOND_BASE, 32'h0);
    test_end("soft reset");
    global_power_down <= 1'b1;
    p.lat <= 100;
    setup(32'h0000_0033);
    send(66, 0);
    wait_blocks(4);
    rchk(`OFS_CONTROL, 32'h0000_2433);
    check(wake_request, 1'b1);
    test_end("keep awake and bandwidth");
    bus(1'b1, `OFS_CONTROL, `SOFT_RESET_WORD);
    global_power_down <= 1'b0;
    unit_power_off <= 1'b1;
    p.lat <= 3;
    setup(32'h0000_0001);
    send(64, 0);
    repeat (40) @(posedge hclk);
    check(p.blocks, 4);
    rchk(`OFS_CONTROL, 32'h0000_4001);
    test_end("unit power off");
    unit_power_off <= 1'b0;
    mode_run(32'h0001_0001, 32, 5, 32'hC301_C300);
    mode_run(32'h0002_0001, 32, 6, 32'h015A_005A);
    mode_run(32'h0003_0001, 16, 7, 32'hC300_005A);
    test_end("capture modes");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
